/* rtl/pmcg_pkg.sv */
// pmcg_pkg: register map, field positions, reset values and mode codes
// assumes one system clock and a byte-wide register port
package pmcg_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PMCG_ADDR_OVERRIDE  = 8'h00_F5;
  localparam logic [7:0] PMCG_ADDR_IDLE_GATE = 8'h00_FE;
  localparam logic [7:0] PMCG_ADDR_CLK_MODE  = 8'h00_FD;
  localparam logic [7:0] PMCG_ADDR_PWR_CTRL  = 8'h00_87;
  localparam logic [7:0] PMCG_ADDR_EXT_MODE  = 8'h00_F0;
  localparam logic [7:0] PMCG_ADDR_STATUS    = 8'h00_F1;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int         PMCG_GROUPS        = 4;
  localparam int         PMCG_BIT_IDLE      = 0;
  localparam int         PMCG_BIT_STOP      = 1;
  localparam int         PMCG_BIT_LPEN      = 2;
  localparam int         PMCG_BIT_SUSPEND   = 0;
  localparam int         PMCG_BIT_SLEEP     = 1;
  localparam logic [7:0] PMCG_RST_OVERRIDE  = 8'h00_00;
  localparam logic [3:0] PMCG_RST_IDLE_GATE = 4'h0_0;
  localparam logic [7:0] PMCG_RST_BYTE      = 8'h00_00;
  localparam logic [15:0] PMCG_RESET_VECTOR = 16'h0000;

  // ----------------------------------------------------------------
  // power modes, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    PMCG_NORMAL  = 6'b00_0001,
    PMCG_IDLE    = 6'b00_0010,
    PMCG_STOP    = 6'b00_0100,
    PMCG_LPIDLE  = 6'b00_1000,
    PMCG_SUSPEND = 6'b01_0000,
    PMCG_SLEEP   = 6'b10_0000
  } pmcg_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pmcg_bus_t;

  typedef struct packed {
    logic       irq;
    logic       int_reset;
    logic       ext_reset;
    logic       wake;
    logic       insn_done;
  } pmcg_evt_t;

  typedef struct packed {
    logic       cpu_clk_en;
    logic       cpu_halt;
    logic       prec_osc_en;
    logic       all_osc_en;
    logic       rtc_osc_en;
    logic       sys_clk_en;
    logic       core_pwr_en;
  } pmcg_ctl_t;

endpackage : pmcg_pkg

/* rtl/pmcg_top.sv */
// pmcg_top: power mode controller and per group clock gating
// assumes events synchronous to mclk_i; gclk_i is the ungated peripheral clock
//
// How it works
// - six power modes held in one-hot state
// - idle bit halts CPU after setting instruction
// - idle keeps registers; peripherals keep running
// - enabled interrupt clears idle, resumes CPU
// - reset ends idle; fetch from zero
// - watchdog reset arrives as internal reset
// - stop halts CPU and precision oscillator
// - only a reset ends stop
// - missing clock reset ends stop
// - low power idle gates CPU clock
// - low power active keeps CPU clocked
// - override bit forces group clock on in low power active only
// - bit 3 drives rtc group
// - bit 2 drives timer group
// - bit 1 drives analog group
// - bit 0 drives serial group
// - override bits 7:4 read zero
// - suspend gates clock, stops oscillators
// - sleep gates core power
// - clock mode bit 2 enables low power
// - idle gate bits enable group clocks
//
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
module pmcg_top
  import pmcg_pkg::*;
(
  input  wire logic                       mclk_i,
  input  wire logic                       sys_rst_i,
  input  wire pmcg_pkg::pmcg_bus_t        bus_i,
  input  wire pmcg_pkg::pmcg_evt_t        evt_i,
  input  wire logic                       gclk_i,
  output logic      [7:0]                 rdata_o,
  output pmcg_pkg::pmcg_ctl_t             ctl_o,
  output logic      [15:0]                fetch_addr_o,
  output logic                            fetch_load_o,
  output logic      [3:0]                 grp_clk_en_o,
  output logic      [3:0]                 grp_clk_o
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  pmcg_mode_t  mode_r;
  logic [3:0]  override_r;
  logic [3:0]  idle_gate_r;
  logic        lp_en_r;
  logic        idle_sel_r;
  logic        stop_sel_r;
  logic        idle_pend_r;
  logic        stop_pend_r;
  logic [1:0]  ext_sel_r;
  logic [3:0]  grp_en_nxt;
  logic        any_reset;

  function automatic logic hit(input pmcg_bus_t b, input logic [7:0] a);
    hit = b.wr && (b.addr == a);
  endfunction : hit

  assign any_reset = evt_i.int_reset | evt_i.ext_reset;

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || any_reset) begin
      override_r  <= PMCG_RST_OVERRIDE[3:0];
      idle_gate_r <= PMCG_RST_IDLE_GATE;
      lp_en_r     <= 1'b0;
    end else begin
      if (hit(bus_i, PMCG_ADDR_OVERRIDE)) override_r <= bus_i.wdata[3:0];
      if (hit(bus_i, PMCG_ADDR_IDLE_GATE)) idle_gate_r <= bus_i.wdata[3:0];
      if (hit(bus_i, PMCG_ADDR_CLK_MODE)) lp_en_r <= bus_i.wdata[PMCG_BIT_LPEN];
    end
  end

  // ----------------------------------------------------------------
  // power control select bits
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || any_reset) begin
      idle_sel_r  <= 1'b0;
      stop_sel_r  <= 1'b0;
      idle_pend_r <= 1'b0;
      stop_pend_r <= 1'b0;
      ext_sel_r   <= 2'b00;
    end else begin
      if (hit(bus_i, PMCG_ADDR_PWR_CTRL)) begin
        idle_sel_r  <= bus_i.wdata[PMCG_BIT_IDLE];
        stop_sel_r  <= bus_i.wdata[PMCG_BIT_STOP];
        idle_pend_r <= bus_i.wdata[PMCG_BIT_IDLE];
        stop_pend_r <= bus_i.wdata[PMCG_BIT_STOP];
      end else if (mode_r == PMCG_IDLE || mode_r == PMCG_LPIDLE) begin
        if (evt_i.irq) idle_sel_r <= 1'b0;
      end else if (evt_i.insn_done) begin
        idle_pend_r <= 1'b0;
        stop_pend_r <= 1'b0;
      end
      if (hit(bus_i, PMCG_ADDR_EXT_MODE)) begin
        ext_sel_r <= bus_i.wdata[1:0];
      end else if (evt_i.wake) begin
        ext_sel_r <= 2'b00;
      end
    end
  end

  // ----------------------------------------------------------------
  // mode state machine
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      mode_r <= PMCG_NORMAL;
    end else begin
      case (mode_r)
        PMCG_NORMAL: begin
          if (any_reset) mode_r <= PMCG_NORMAL;
          else if (stop_pend_r && evt_i.insn_done) mode_r <= PMCG_STOP;
          else if (idle_pend_r && evt_i.insn_done)
            mode_r <= lp_en_r ? PMCG_LPIDLE : PMCG_IDLE;
          else if (ext_sel_r[PMCG_BIT_SLEEP]) mode_r <= PMCG_SLEEP;
          else if (ext_sel_r[PMCG_BIT_SUSPEND]) mode_r <= PMCG_SUSPEND;
        end
        PMCG_IDLE, PMCG_LPIDLE: begin
          if (any_reset || evt_i.irq) mode_r <= PMCG_NORMAL;
        end
        PMCG_STOP: begin
          if (any_reset) mode_r <= PMCG_NORMAL;
        end
        PMCG_SUSPEND, PMCG_SLEEP: begin
          if (evt_i.wake || any_reset) mode_r <= PMCG_NORMAL;
        end
        default: mode_r <= PMCG_NORMAL;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // reset vector load
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      fetch_load_o <= 1'b1;
      fetch_addr_o <= PMCG_RESET_VECTOR;
    end else begin
      fetch_load_o <= any_reset;
      fetch_addr_o <= PMCG_RESET_VECTOR;
    end
  end

  // ----------------------------------------------------------------
  // core and oscillator controls
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ctl_o <= '{cpu_clk_en: 1'b1, cpu_halt: 1'b0, prec_osc_en: 1'b1,
                 all_osc_en: 1'b1, rtc_osc_en: 1'b1, sys_clk_en: 1'b1,
                 core_pwr_en: 1'b1};
    end else begin
      // CPU clock gated in low power idle, stop, suspend and sleep
      ctl_o.cpu_clk_en  <= !(mode_r == PMCG_LPIDLE || mode_r == PMCG_STOP ||
                             mode_r == PMCG_SUSPEND || mode_r == PMCG_SLEEP);
      ctl_o.cpu_halt    <= (mode_r != PMCG_NORMAL);
      ctl_o.prec_osc_en <= !(mode_r == PMCG_STOP || mode_r == PMCG_SUSPEND ||
                             mode_r == PMCG_SLEEP);
      ctl_o.all_osc_en  <= !(mode_r == PMCG_SUSPEND || mode_r == PMCG_SLEEP);
      ctl_o.rtc_osc_en  <= (mode_r != PMCG_SUSPEND);
      ctl_o.sys_clk_en  <= !(mode_r == PMCG_SUSPEND || mode_r == PMCG_SLEEP);
      ctl_o.core_pwr_en <= (mode_r != PMCG_SLEEP);
    end
  end

  // ----------------------------------------------------------------
  // group clock enables
  // ----------------------------------------------------------------
  always_comb begin
    grp_en_nxt = {PMCG_GROUPS{1'b1}};
    if (mode_r == PMCG_LPIDLE) begin
      grp_en_nxt = idle_gate_r;
    end else if (mode_r == PMCG_NORMAL && lp_en_r) begin
      grp_en_nxt = override_r | idle_gate_r;
    end else if (mode_r == PMCG_STOP || mode_r == PMCG_SUSPEND ||
                 mode_r == PMCG_SLEEP) begin
      grp_en_nxt = '0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) grp_clk_en_o <= {PMCG_GROUPS{1'b1}};
    else grp_clk_en_o <= grp_en_nxt;
  end

  genvar g;
  generate
    for (g = 0; g < PMCG_GROUPS; g++) begin : g_gate
      logic lat_r;
      // enable moves only while clock low
      always_ff @(negedge gclk_i) begin
        if (sys_rst_i) lat_r <= 1'b1;
        else lat_r <= grp_clk_en_o[g];
      end
      always_comb grp_clk_o[g] = gclk_i & lat_r;
    end
  endgenerate

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rdata_o <= PMCG_RST_BYTE;
    end else if (bus_i.rd) begin
      case (bus_i.addr)
        PMCG_ADDR_OVERRIDE:  rdata_o <= {4'h0, override_r};
        PMCG_ADDR_IDLE_GATE: rdata_o <= {4'h0, idle_gate_r};
        PMCG_ADDR_CLK_MODE:  rdata_o <= {5'h00, lp_en_r, 2'b00};
        PMCG_ADDR_PWR_CTRL:  rdata_o <= {6'h00, stop_sel_r, idle_sel_r};
        PMCG_ADDR_EXT_MODE:  rdata_o <= {6'h00, ext_sel_r};
        PMCG_ADDR_STATUS:    rdata_o <= {2'b00, mode_r};
        default:             rdata_o <= PMCG_RST_BYTE;
      endcase
    end else begin
      rdata_o <= PMCG_RST_BYTE;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_stop_exit_reset: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (mode_r == PMCG_STOP && !any_reset) |=> mode_r == PMCG_STOP)
    else $error("stop left without reset");
  a_irq_idle_exit: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (mode_r == PMCG_IDLE && evt_i.irq) |=> mode_r == PMCG_NORMAL && !idle_sel_r)
    else $error("interrupt did not end idle");
  a_lpidle_cpu_gate: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    mode_r == PMCG_LPIDLE |=> !ctl_o.cpu_clk_en)
    else $error("cpu clock running in low power idle");
  a_active_cpu_clk: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    mode_r == PMCG_NORMAL |=> ctl_o.cpu_clk_en)
    else $error("cpu clock gated while active");
  a_override_force: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (mode_r == PMCG_NORMAL && lp_en_r && override_r[0]) |=> grp_clk_en_o[0])
    else $error("override did not force clock");
  a_lpidle_gate_map: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    mode_r == PMCG_LPIDLE |=> grp_clk_en_o == $past(idle_gate_r))
    else $error("idle gate mismatch");
  a_override_hi_zero: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (bus_i.rd && bus_i.addr == PMCG_ADDR_OVERRIDE) |=> rdata_o[7:4] == 4'h0)
    else $error("override upper bits nonzero");
  a_stop_osc_off: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    mode_r == PMCG_STOP |=> !ctl_o.prec_osc_en && ctl_o.rtc_osc_en)
    else $error("oscillator state wrong in stop");
  a_reset_vector: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    any_reset |=> fetch_load_o && fetch_addr_o == 16'h0000)
    else $error("reset vector not loaded");
  a_sleep_power: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    mode_r == PMCG_SLEEP |=> !ctl_o.core_pwr_en)
    else $error("core power on in sleep");

  // ----------------------------------------------------------------
  // mode state, entry and exit checks
  // ----------------------------------------------------------------
  a_mode_onehot: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $onehot(mode_r))
    else $error("mode state not one-hot");

  a_idle_entry: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (mode_r == PMCG_NORMAL && !any_reset && !stop_pend_r && idle_pend_r &&
     evt_i.insn_done && !lp_en_r) |=> mode_r == PMCG_IDLE)
    else $error("idle not entered after instruction");

  a_lpidle_entry: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (mode_r == PMCG_NORMAL && !any_reset && !stop_pend_r && idle_pend_r &&
     evt_i.insn_done && lp_en_r) |=> mode_r == PMCG_LPIDLE)
    else $error("low power idle not entered");

  a_stop_entry: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (mode_r == PMCG_NORMAL && !any_reset && stop_pend_r && evt_i.insn_done)
    |=> mode_r == PMCG_STOP)
    else $error("stop not entered after instruction");

  a_idle_halt: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    mode_r == PMCG_IDLE |=> ctl_o.cpu_halt)
    else $error("cpu not halted in idle");

  a_idle_osc_on: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    mode_r == PMCG_IDLE |=> ctl_o.prec_osc_en && ctl_o.sys_clk_en)
    else $error("clock source stopped in idle");

  a_idle_groups_on: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    mode_r == PMCG_IDLE |=> grp_clk_en_o == 4'h0_F)
    else $error("peripheral clock gated in idle");

  a_idle_reset_exit: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ((mode_r == PMCG_IDLE || mode_r == PMCG_LPIDLE) && any_reset)
    |=> mode_r == PMCG_NORMAL)
    else $error("reset did not end idle");

  a_reset_clears_sel: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    any_reset |=> !idle_sel_r && !stop_sel_r)
    else $error("select bits survive reset");

  a_lpidle_irq_exit: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (mode_r == PMCG_LPIDLE && evt_i.irq) |=> mode_r == PMCG_NORMAL)
    else $error("interrupt did not end low power idle");

  a_stop_cpu_halt: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    mode_r == PMCG_STOP |=> ctl_o.cpu_halt && !ctl_o.cpu_clk_en)
    else $error("cpu running in stop");

  a_stop_reset_end: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (mode_r == PMCG_STOP && any_reset) |=> mode_r == PMCG_NORMAL)
    else $error("internal reset did not end stop");

  // ----------------------------------------------------------------
  // group clock checks
  // ----------------------------------------------------------------
  a_override_rtc: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (mode_r == PMCG_NORMAL && lp_en_r && override_r[3]) |=> grp_clk_en_o[3])
    else $error("rtc group not forced on");

  a_override_timer: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (mode_r == PMCG_NORMAL && lp_en_r && override_r[2]) |=> grp_clk_en_o[2])
    else $error("timer group not forced on");

  a_override_analog: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (mode_r == PMCG_NORMAL && lp_en_r && override_r[1]) |=> grp_clk_en_o[1])
    else $error("analog group not forced on");

  a_override_revert: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (mode_r == PMCG_NORMAL && lp_en_r && !override_r[0] && !idle_gate_r[0])
    |=> !grp_clk_en_o[0])
    else $error("cleared override did not revert");

  a_normal_groups_on: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (mode_r == PMCG_NORMAL && !lp_en_r) |=> grp_clk_en_o == 4'h0_F)
    else $error("group gated without low power enable");

  a_lpen_write: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (hit(bus_i, PMCG_ADDR_CLK_MODE) && !any_reset && bus_i.wdata[PMCG_BIT_LPEN])
    |=> lp_en_r)
    else $error("low power enable not stored");

  a_gate_write: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (hit(bus_i, PMCG_ADDR_IDLE_GATE) && !any_reset && bus_i.wdata[0]) |=> idle_gate_r[0])
    else $error("idle gate bit not stored");

  a_halted_groups_off: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (mode_r == PMCG_STOP || mode_r == PMCG_SUSPEND || mode_r == PMCG_SLEEP)
    |=> grp_clk_en_o == 4'h0)
    else $error("group clock running while halted");

  // ----------------------------------------------------------------
  // suspend and sleep checks
  // ----------------------------------------------------------------
  a_suspend_clk_off: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    mode_r == PMCG_SUSPEND |=> !ctl_o.sys_clk_en && !ctl_o.all_osc_en)
    else $error("clock running in suspend");

  a_suspend_wake: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (mode_r == PMCG_SUSPEND && evt_i.wake) |=> mode_r == PMCG_NORMAL)
    else $error("wake did not end suspend");

  a_sleep_osc_off: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    mode_r == PMCG_SLEEP |=> !ctl_o.all_osc_en && ctl_o.rtc_osc_en)
    else $error("oscillator state wrong in sleep");

  a_sleep_wake: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (mode_r == PMCG_SLEEP && evt_i.wake) |=> mode_r == PMCG_NORMAL)
    else $error("wake did not end sleep");

endmodule : pmcg_top

/* tb/pmcg_cpu_model.sv */
// pmcg_cpu_model: cpu core and peripheral clock source facing the block
// assumes the bench requests instruction retirement one cycle ahead
`timescale 1ns/10ps
module pmcg_cpu_model (
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  input  wire logic retire_req_i,
  output logic      insn_done_o,
  output logic      gclk_o
);
  // ------------------------------------------------------------
  // free running peripheral clock
  // ------------------------------------------------------------
  initial begin
    gclk_o = 1'b0;
    forever #3.5 gclk_o = ~gclk_o;
  end
  // ------------------------------------------------------------
  // instruction completion
  // ------------------------------------------------------------
  // setting instruction completes
  always_ff @(posedge mclk_i) begin
    insn_done_o <= sys_rst_i ? 1'b0 : retire_req_i;
  end
endmodule : pmcg_cpu_model

/* tb/tb_power_mode_clock_gating.sv */
// tb_power_mode_clock_gating: self-checking bench of pmcg_top
// assumes register map and mode codes of pmcg_pkg
`timescale 1ns/10ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: %h vs %h", $time, (a), (e)); end end
module tb_power_mode_clock_gating;
  import pmcg_pkg::*;
  logic       mclk_i, sys_rst_i, irq, int_rst, ext_rst, wake, retire, insn_done, gclk;
  pmcg_bus_t  bus;
  pmcg_ctl_t  ctl;
  logic [7:0] rdata, d;
  logic [15:0] fetch_addr;
  logic       fetch_load;
  logic [3:0] grp_en, grp_clk;
  int         num_errors, n_tests, seed, ovr, gate, lpen;
  pmcg_mode_t mode;
  // ------------------------------------------------------------
  // design and partner
  // ------------------------------------------------------------
  pmcg_top dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .bus_i(bus),
    .evt_i({irq, int_rst, ext_rst, wake, insn_done}), .gclk_i(gclk), .rdata_o(rdata),
    .ctl_o(ctl), .fetch_addr_o(fetch_addr), .fetch_load_o(fetch_load),
    .grp_clk_en_o(grp_en), .grp_clk_o(grp_clk));
  pmcg_cpu_model cpu_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .retire_req_i(retire),
    .insn_done_o(insn_done), .gclk_o(gclk));
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  // ------------------------------------------------------------
  // model and tasks
  // ------------------------------------------------------------
  function automatic logic [3:0] exp_grp();
    case (mode)
      PMCG_NORMAL: return lpen ? 4'(ovr | gate) : 4'hF;
      PMCG_IDLE:   return 4'hF;
      PMCG_LPIDLE: return 4'(gate);
      default:     return 4'h0;
    endcase
  endfunction : exp_grp
  task automatic summarize();
    if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk_i); bus.wr <= 1'b1; bus.addr <= a; bus.wdata <= v;
    @(posedge mclk_i); bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk_i); bus.rd <= 1'b1; bus.addr <= a;
    @(posedge mclk_i); bus.rd <= 1'b0;
    #1 v = rdata;
  endtask : rd
  task automatic ev(input int k);
    @(posedge mclk_i);
    case (k)
      0: irq <= 1'b1;
      1: int_rst <= 1'b1;
      2: ext_rst <= 1'b1;
      3: wake <= 1'b1;
      default: retire <= 1'b1;
    endcase
    @(posedge mclk_i); {irq, int_rst, ext_rst, wake, retire} <= '0;
    if (k == 1 || k == 2) begin
      ovr = 0; gate = 0; lpen = 0; mode = PMCG_NORMAL;
    end
    if (k < 4 && mode != PMCG_STOP) mode = PMCG_NORMAL;
  endtask : ev
  task automatic wait_mode();
    for (int i = 0; i < 20; i++) begin
      rd(PMCG_ADDR_STATUS, d);
      if (d === 8'(mode)) break;
    end
    `CHK(d, 8'(mode))
  endtask : wait_mode
  task automatic enter(input logic [7:0] a, input logic [7:0] v, input pmcg_mode_t m);
    wr(a, v); ev(4); mode = m; wait_mode();
    `CHK(grp_en, exp_grp())
  endtask : enter
  // group 0 gated clock edges only follow source edges
  always @(grp_clk[0]) if (!sys_rst_i && n_tests > 0) `CHK(grp_clk[0], gclk)
  initial begin
    repeat (50000) @(posedge mclk_i);
    num_errors++;
    summarize();
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    seed = 32'h2703; bus = '0; {irq, int_rst, ext_rst, wake, retire} = '0;
    num_errors = 0; n_tests = 0; ovr = 0; gate = 0; lpen = 0; mode = PMCG_NORMAL;
    sys_rst_i = 1'b1;
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    rd(PMCG_ADDR_OVERRIDE, d); `CHK(d, PMCG_RST_OVERRIDE)
    rd(PMCG_ADDR_CLK_MODE, d); `CHK(d, 8'h00_00)
    rd(8'h00_10, d); `CHK(d, 8'h00_00)
    `CHK(grp_en, 4'hF)
    for (int i = 0; i < 4; i++) begin
      ovr = $random(seed);
      wr(PMCG_ADDR_OVERRIDE, 8'(ovr)); ovr = ovr & 15;
      rd(PMCG_ADDR_OVERRIDE, d); `CHK(d, 8'(ovr))
    end
    // override and gate written before the enable bit
    for (int i = 0; i < 4; i++) begin
      gate = 0; ovr = 1 << i; lpen = 1;
      wr(PMCG_ADDR_IDLE_GATE, 8'h00_00); wr(PMCG_ADDR_OVERRIDE, 8'(ovr));
      wr(PMCG_ADDR_CLK_MODE, 8'h00_04);
      repeat (3) @(posedge mclk_i); #1;
      `CHK(grp_en, exp_grp())
      `CHK(ctl.cpu_clk_en, 1'b1)
    end
    gate = $random(seed) & 15; ovr = 0;
    wr(PMCG_ADDR_OVERRIDE, 8'h00_00); wr(PMCG_ADDR_IDLE_GATE, 8'(gate));
    enter(PMCG_ADDR_PWR_CTRL, 8'h00_01, PMCG_LPIDLE);
    `CHK(ctl.cpu_clk_en, 1'b0)
    ev(0); wait_mode();
    rd(PMCG_ADDR_PWR_CTRL, d); `CHK(d[0], 1'b0)
    wr(PMCG_ADDR_CLK_MODE, 8'h00_00); lpen = 0;
    enter(PMCG_ADDR_PWR_CTRL, 8'h00_01, PMCG_IDLE);
    `CHK(ctl.cpu_halt, 1'b1)
    ev(2); #1;
    for (int i = 0; i < 5 && fetch_load !== 1'b1; i++) @(posedge mclk_i);
    `CHK(fetch_load, 1'b1)
    `CHK(fetch_addr, PMCG_RESET_VECTOR)
    wait_mode(); rd(PMCG_ADDR_IDLE_GATE, d); `CHK(d, 8'h00_00)
    enter(PMCG_ADDR_PWR_CTRL, 8'h00_01, PMCG_IDLE);
    ev(1); wait_mode();
    enter(PMCG_ADDR_PWR_CTRL, 8'h00_02, PMCG_STOP);
    `CHK({ctl.prec_osc_en, ctl.cpu_halt}, 2'b01)
    ev(0); repeat (4) @(posedge mclk_i); wait_mode();
    ev(1); wait_mode();
    for (int k = 0; k < 2; k++) begin
      enter(PMCG_ADDR_EXT_MODE, 8'(1 << k), k ? PMCG_SLEEP : PMCG_SUSPEND);
      if (k == 0) `CHK({ctl.sys_clk_en, ctl.all_osc_en}, 2'b00)
      else `CHK({ctl.core_pwr_en, ctl.rtc_osc_en}, 2'b01)
      ev(3); wait_mode();
    end
    summarize();
  end
endmodule : tb_power_mode_clock_gating
